// File: design/gds_pkg.sv
// Shared constants and types of the gate driver fault supervisor
package gds_pkg;
  // Serial frame layout: rw flag, address, data
  localparam logic [4:0] GDS_FRAME_CNT = 5'h10;
  localparam logic [4:0] GDS_HDR_CNT = 5'h05;
  // Register offsets
  localparam logic [3:0] GDS_ADDR_STATUS = 4'h1;
  localparam logic [3:0] GDS_ADDR_OC_STATUS = 4'h2;
  localparam logic [3:0] GDS_ADDR_TIMING = 4'h7;
  localparam logic [3:0] GDS_ADDR_CLEAR = 4'h9;
  localparam logic [3:0] GDS_ADDR_OC_CTRL = 4'hc;
  // Reset values
  localparam logic [10:0] GDS_TIMING_RST = 11'h000;
  localparam logic [10:0] GDS_CLEAR_RST = 11'h000;
  localparam logic [10:0] GDS_OC_CTRL_RST = 11'h000;
  // Field positions
  localparam int GDS_DEAD_LSB = 4;
  localparam int GDS_BLANK_LSB = 2;
  localparam int GDS_DEGL_LSB = 0;
  localparam int GDS_CLR_BIT = 1;
  localparam int GDS_THR_LSB = 3;
  localparam int GDS_MODE_LSB = 0;
  // Overcurrent response modes
  localparam logic [2:0] GDS_OC_LATCHED = 3'h0;
  localparam logic [2:0] GDS_OC_REPORT = 3'h1;
  localparam logic [2:0] GDS_OC_DISABLED = 3'h2;
  // Timing, clock period 10 ns
  localparam int GDS_CLK_NS = 10;
  localparam int GDS_HOLD_US = 56;
  localparam int GDS_HOLD_CYC = GDS_HOLD_US * 1000 / GDS_CLK_NS;
  localparam int GDS_DEAD_MIN_NS = 40;
  localparam logic [5:0] GDS_DEAD_STEP_CYC = 6'((GDS_DEAD_MIN_NS + GDS_CLK_NS - 1) / GDS_CLK_NS);
  // Blanking and deglitch in 10 ns cycles: 0, 1.75, 3.5 and 7 us
  localparam logic [9:0] GDS_BLANK_CYC_0 = 10'h000;
  localparam logic [9:0] GDS_BLANK_CYC_1 = 10'h0af;
  localparam logic [9:0] GDS_BLANK_CYC_2 = 10'h15e;
  localparam logic [9:0] GDS_BLANK_CYC_3 = 10'h2bc;
  localparam logic [9:0] GDS_DEGL_CYC_0 = 10'h000;
  localparam logic [9:0] GDS_DEGL_CYC_1 = 10'h0af;
  localparam logic [9:0] GDS_DEGL_CYC_2 = 10'h15e;
  localparam logic [9:0] GDS_DEGL_CYC_3 = 10'h2bc;
  // Fault indicator pin states
  typedef enum logic [3:0] {
    GDS_FI_IDLE = 4'b0001,
    GDS_FI_LOW = 4'b0010,
    GDS_FI_HIGH = 4'b0100,
    GDS_FI_FAULT = 4'b1000
  } gds_fi_state_t;
  // Supply-good states
  typedef enum logic [2:0] {
    GDS_SG_OK = 3'b001,
    GDS_SG_HOLD = 3'b010,
    GDS_SG_WAIT = 3'b100
  } gds_sg_state_t;
endpackage : gds_pkg

// File: design/gds_fet_channel.sv
// One MOSFET channel: dead time, blanking and overcurrent deglitch
module gds_fet_channel
  import gds_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic cmd_on,
  input wire logic partner_clear,
  input wire logic shutdown,
  input wire logic vds_trip,
  input wire logic [5:0] dead_cycles,
  input wire logic [CNT_W-1:0] blank_cycles,
  input wire logic [CNT_W-1:0] deglitch_cycles,
  output logic gate_on,
  output logic ocp_trip
);
  logic cmd_d;
  logic [5:0] dead_cnt;
  logic [CNT_W-1:0] blank_cnt;
  logic [CNT_W-1:0] degl_cnt;
  logic monitor;

  // Command edge, used to start blanking
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cmd_d <= 1'b0;
    end else if (ce) begin
      cmd_d <= cmd_on;
    end
  end

  // Enable only after partner is below cutoff plus the digital dead time
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dead_cnt <= 6'h00;
      gate_on <= 1'b0;
    end else if (ce) begin
      if (!cmd_on || shutdown) begin
        dead_cnt <= 6'h00;
        gate_on <= 1'b0;
      end else if (!gate_on) begin
        if (!partner_clear) begin
          dead_cnt <= 6'h00;
        end else if (dead_cnt >= dead_cycles) begin
          gate_on <= 1'b1;
        end else begin
          dead_cnt <= dead_cnt + 6'h01;
        end
      end
    end
  end

  // Blanking starts at the command, so it overlaps the dead time
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      blank_cnt <= '0;
    end else if (ce) begin
      if (cmd_on && !cmd_d) begin
        blank_cnt <= blank_cycles;
      end else if (blank_cnt != '0) begin
        blank_cnt <= blank_cnt - 1'b1;
      end
    end
  end

  assign monitor = gate_on && (blank_cnt == '0) && vds_trip;

  // Trip must persist through the deglitch window
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      degl_cnt <= '0;
      ocp_trip <= 1'b0;
    end else if (ce) begin
      if (!monitor) begin
        degl_cnt <= '0;
        ocp_trip <= 1'b0;
      end else if (degl_cnt >= deglitch_cycles) begin
        ocp_trip <= 1'b1;
      end else begin
        degl_cnt <= degl_cnt + 1'b1;
      end
    end
  end
endmodule : gds_fet_channel

// File: design/gds_supervisor.sv
// Fault and warning supervisor with serial register access
//
// Contract
// - Pending warning toggles fault pin: 56 us low, 56 us released.
// - Reading the status register holding the warning stops its pulses.
// - Warning status bit stays set while condition persists, clears on the first status read after it passed.
// - Acknowledged warning pulses again only after its condition clears and recurs.
// - Warnings only report; they never touch gate outputs.
// - Fault holds fault pin low and sets the summary fault bit at 0x1.
// - Fault also sets the bit naming the specific error type.
// - Fault is latched and turns all gate outputs off until recovery.
// - Fault during a warning wins: pin latched low, gates shut down.
// - Clear bit returns to zero once faults are reset and pin released.
// - Thermal flags never touch the fault pin; status follows them live.
// - Watchdog and regulator undervoltage are signalled on supply good.
// - Regulator leaving its window drives supply good low for 56 us.
// - After 56 us, supply good stays low until regulator recovers.
// - Digital dead time from 0x7 D6-D4, at least 40 ns, after handshake.
// - Opposite MOSFET enabled only after turning-off one is below cutoff.
// - Overcurrent threshold from 0xC D7-D3, writable while running.
// - Comparators ignored for blanking time from 0x7 D3-D2 after turn-on.
// - Trip counts only if it lasts the deglitch time from 0x7 D1-D0.
// - Overcurrent response mode selected by 0xC D2-D0.
// - Dead time and blanking run together from the switching command.
// - Latched mode: gates off, pin latched, tripping MOSFET recorded.
// - Report mode: flag on pin and status, gates keep running.
// - Disabled mode: overcurrent neither acted on nor reported.
module gds_supervisor
  import gds_pkg::*;
#(
  parameter int HOLD_CYCLES = GDS_HOLD_CYC,
  parameter int NUM_WARN = 4,
  parameter int NUM_FAULT = 4
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic gate_enable,
  input wire logic [5:0] gate_cmd,
  input wire logic [5:0] vgs_below_cutoff,
  input wire logic [5:0] vds_trip,
  input wire logic [NUM_WARN-1:0] warn_cond,
  input wire logic [NUM_FAULT-1:0] fault_cond,
  input wire logic [3:0] thermal_flag,
  input wire logic regulator_undervolt,
  input wire logic watchdog_fault,
  output logic [5:0] gate_out,
  output logic fault_indicator_n_o,
  output logic fault_indicator_n_oe,
  output logic supply_good_out,
  output logic [4:0] overcurrent_threshold_sel
);
  localparam int SW = 3 + 1 + 18 + NUM_WARN + NUM_FAULT + 4 + 2;
  localparam logic [SW-1:0] SYNC_RST = {1'b0, 1'b1, {(SW - 2){1'b0}}};
  localparam int TW = $clog2(HOLD_CYCLES + 1);
  localparam int NW = NUM_WARN + 1;

  logic [SW-1:0] sync1, sync2;
  logic sclk_s, cs_n_s, mosi_s, gate_en_s, reg_uv_s, wd_s;
  logic [5:0] cmd_s, vgs_s, vds_s;
  logic [NUM_WARN-1:0] warn_s;
  logic [NUM_FAULT-1:0] fault_s;
  logic [3:0] therm_s;
  logic sclk_q, cs_n_q, gate_en_q, reg_uv_q, wd_q;

  // Pins come from outside the clock domain: two flip-flops first
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
    end else if (ce) begin
      sync1 <= {spi_sclk, spi_cs_n, spi_mosi, gate_enable, gate_cmd, vgs_below_cutoff,
                vds_trip, warn_cond, fault_cond, thermal_flag, regulator_undervolt,
                watchdog_fault};
      sync2 <= sync1;
    end
  end
  assign {sclk_s, cs_n_s, mosi_s, gate_en_s, cmd_s, vgs_s, vds_s, warn_s, fault_s, therm_s,
          reg_uv_s, wd_s} = sync2;

  // Previous synced values for edge detection
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      gate_en_q <= 1'b0;
      reg_uv_q <= 1'b0;
      wd_q <= 1'b0;
    end else if (ce) begin
      sclk_q <= sclk_s;
      cs_n_q <= cs_n_s;
      gate_en_q <= gate_en_s;
      reg_uv_q <= reg_uv_s;
      wd_q <= wd_s;
    end
  end

  // ---- Serial slave: mode 1, rw + 4-bit address + 11 data bits
  logic [15:0] sh_in;
  logic [4:0] bit_cnt;
  logic [10:0] sh_out;
  logic [10:0] rd_mux;
  logic [3:0] hdr_addr;
  logic sclk_fall, sclk_rise, frame_end, wr_stb, rd_stb;
  logic [10:0] timing_reg, clear_reg, oc_ctrl_reg, status_reg, oc_status_reg;

  assign sclk_fall = sclk_q && !sclk_s && !cs_n_s;
  assign sclk_rise = !sclk_q && sclk_s && !cs_n_s;
  assign frame_end = !cs_n_q && cs_n_s && (bit_cnt == GDS_FRAME_CNT);
  assign wr_stb = frame_end && !sh_in[15];
  assign rd_stb = frame_end && sh_in[15];
  assign hdr_addr = {sh_in[2:0], mosi_s};

  // Shift in on falling edges; capture read data once header is in
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sh_in <= 16'h0000;
      bit_cnt <= 5'h00;
      sh_out <= 11'h000;
    end else if (ce) begin
      if (cs_n_s) begin
        bit_cnt <= 5'h00;
      end else if (sclk_fall && bit_cnt != GDS_FRAME_CNT) begin
        sh_in <= {sh_in[14:0], mosi_s};
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == GDS_HDR_CNT - 5'h01) begin
          sh_out <= sh_in[3] ? rd_mux : 11'h000;
        end
      end else if (sclk_rise && bit_cnt >= GDS_HDR_CNT) begin
        sh_out <= {sh_out[9:0], 1'b0};
      end
    end
  end

  // Data out changes on rising edges, master samples on falling
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      spi_sdo <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else if (ce) begin
      spi_sdo_oe <= !cs_n_s;
      if (sclk_rise && bit_cnt >= GDS_HDR_CNT) begin
        spi_sdo <= sh_out[10];
      end else if (cs_n_s) begin
        spi_sdo <= 1'b0;
      end
    end
  end

  // Read multiplexer, unmapped addresses read zero
  always_comb begin
    case (hdr_addr)
      GDS_ADDR_STATUS: rd_mux = status_reg;
      GDS_ADDR_OC_STATUS: rd_mux = oc_status_reg;
      GDS_ADDR_TIMING: rd_mux = timing_reg;
      GDS_ADDR_CLEAR: rd_mux = clear_reg;
      GDS_ADDR_OC_CTRL: rd_mux = oc_ctrl_reg;
      default: rd_mux = 11'h000;
    endcase
  end

  // Control registers; threshold and mode may change while running
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      timing_reg <= GDS_TIMING_RST;
      oc_ctrl_reg <= GDS_OC_CTRL_RST;
    end else if (ce && wr_stb) begin
      if (sh_in[14:11] == GDS_ADDR_TIMING) begin
        timing_reg <= sh_in[10:0];
      end
      if (sh_in[14:11] == GDS_ADDR_OC_CTRL) begin
        oc_ctrl_reg <= sh_in[10:0];
      end
    end
  end

  // Threshold select is registered once, then drives the analog comparators
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      overcurrent_threshold_sel <= GDS_OC_CTRL_RST[GDS_THR_LSB +: 5];
    end else if (ce) begin
      overcurrent_threshold_sel <= oc_ctrl_reg[GDS_THR_LSB +: 5];
    end
  end

  // ---- Timing selections
  logic [2:0] oc_mode;
  logic [5:0] dead_cycles;
  logic [9:0] blank_cycles, degl_cycles;
  assign oc_mode = oc_ctrl_reg[GDS_MODE_LSB +: 3];
  assign dead_cycles = 6'(GDS_DEAD_STEP_CYC * ({3'h0, timing_reg[GDS_DEAD_LSB +: 3]} + 6'h01));

  always_comb begin
    case (timing_reg[GDS_BLANK_LSB +: 2])
      2'h0: blank_cycles = GDS_BLANK_CYC_0;
      2'h1: blank_cycles = GDS_BLANK_CYC_1;
      2'h2: blank_cycles = GDS_BLANK_CYC_2;
      default: blank_cycles = GDS_BLANK_CYC_3;
    endcase
    case (timing_reg[GDS_DEGL_LSB +: 2])
      2'h0: degl_cycles = GDS_DEGL_CYC_0;
      2'h1: degl_cycles = GDS_DEGL_CYC_1;
      2'h2: degl_cycles = GDS_DEGL_CYC_2;
      default: degl_cycles = GDS_DEGL_CYC_3;
    endcase
  end

  // ---- Gate channels, high sides 0..2 paired with low sides 3..5
  logic [5:0] gate_on, ocp_trip;
  logic fault_lat;
  logic oc_latched, oc_report;
  assign oc_latched = (oc_mode == GDS_OC_LATCHED);
  assign oc_report = (oc_mode == GDS_OC_REPORT);

  for (genvar i = 0; i < 6; i++) begin : g_fet
    localparam int P = (i < 3) ? i + 3 : i - 3;
    gds_fet_channel #(.CNT_W(10)) u_chan (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .ce(ce),
      .cmd_on(cmd_s[i] && !cmd_s[P]),
      .partner_clear(!gate_on[P] && vgs_s[P]),
      .shutdown(fault_lat || !gate_en_s),
      .vds_trip(vds_s[i]),
      .dead_cycles(dead_cycles),
      .blank_cycles(blank_cycles),
      .deglitch_cycles(degl_cycles),
      .gate_on(gate_on[i]),
      .ocp_trip(ocp_trip[i])
    );
  end

  // ---- Fault latch and recovery
  logic fault_now, clear_req, clear_ok, clear_do;
  logic [NUM_FAULT-1:0] fault_type;
  logic wd_type;
  logic [5:0] oc_stat;
  logic [5:0] ocp_q;
  assign fault_now = (|fault_s) || wd_s || (oc_latched && (|ocp_trip));
  assign clear_req = clear_reg[GDS_CLR_BIT] || (gate_en_s && !gate_en_q);
  assign clear_ok = !fault_now;
  assign clear_do = clear_req && clear_ok;

  // Set wins over clear, so a fault arriving during recovery stays
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      fault_lat <= 1'b0;
      fault_type <= '0;
      wd_type <= 1'b0;
    end else if (ce) begin
      fault_lat <= fault_now || (fault_lat && !clear_do);
      fault_type <= fault_s | (fault_type & {NUM_FAULT{!clear_do}});
      wd_type <= wd_s || (wd_type && !clear_do);
    end
  end

  // Gate outputs forced off at once on any fault; warnings never reach here
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      gate_out <= 6'h00;
    end else if (ce) begin
      gate_out <= (fault_lat || fault_now || !gate_en_s) ? 6'h00 : gate_on;
    end
  end

  // Per-MOSFET overcurrent record; disabled mode records nothing
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      oc_stat <= 6'h00;
      ocp_q <= 6'h00;
    end else if (ce) begin
      ocp_q <= ocp_trip;
      if (!oc_latched && !oc_report) begin
        oc_stat <= 6'h00;
      end else if (rd_stb && sh_in[14:11] == GDS_ADDR_OC_STATUS && !oc_latched) begin
        oc_stat <= ocp_trip;
      end else begin
        oc_stat <= ocp_trip | (oc_stat & {6{!clear_do}});
      end
    end
  end

  // Clear bit: written by software, drops itself once faults are gone
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      clear_reg <= GDS_CLEAR_RST;
    end else if (ce) begin
      if (wr_stb && sh_in[14:11] == GDS_ADDR_CLEAR) begin
        clear_reg <= sh_in[10:0];
      end else if (clear_reg[GDS_CLR_BIT] && !fault_lat && !fault_indicator_n_oe) begin
        clear_reg[GDS_CLR_BIT] <= 1'b0;
      end
    end
  end

  // ---- Warnings: latched reporting, read acknowledges the pin pulses
  logic [NW-1:0] warn_src, warn_prev, warn_pend, warn_stat, warn_ack;
  assign warn_src = {oc_report && (|(ocp_trip & ~ocp_q)) || (oc_report && (|ocp_trip)), warn_s};
  assign warn_ack = {rd_stb && sh_in[14:11] == GDS_ADDR_OC_STATUS,
                     {NUM_WARN{rd_stb && sh_in[14:11] == GDS_ADDR_STATUS}}};

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      warn_prev <= '0;
      warn_pend <= '0;
      warn_stat <= '0;
    end else if (ce) begin
      warn_prev <= warn_src;
      // New occurrence only on a fresh rise, so an acknowledged one stays quiet
      warn_pend <= (warn_src & ~warn_prev) | (warn_pend & ~warn_ack);
      // Status holds while the condition lasts, drops at the first read after it passed
      warn_stat <= warn_src | (warn_stat & ~(warn_ack & ~warn_src));
    end
  end

  // Status words; thermal flags are live and never drive the pin
  assign status_reg = {fault_lat, wd_type, reg_uv_s, therm_s, warn_stat[NUM_WARN-1:0]};
  assign oc_status_reg = {1'b0, fault_type, oc_stat};

  // ---- Fault indicator pin: fault beats warning pulses
  gds_fi_state_t fi_state, next_fi_state;
  logic [TW-1:0] fi_cnt;
  logic fi_done;
  assign fi_done = (fi_cnt == TW'(HOLD_CYCLES - 1));

  always_comb begin
    next_fi_state = fi_state;
    case (fi_state)
      GDS_FI_IDLE: if (|warn_pend) next_fi_state = GDS_FI_LOW;
      GDS_FI_LOW: if (fi_done) next_fi_state = GDS_FI_HIGH;
      GDS_FI_HIGH: begin
        if (!(|warn_pend)) begin
          next_fi_state = GDS_FI_IDLE;
        end else if (fi_done) begin
          next_fi_state = GDS_FI_LOW;
        end
      end
      GDS_FI_FAULT: if (!fault_lat) next_fi_state = GDS_FI_IDLE;
      default: next_fi_state = GDS_FI_IDLE;
    endcase
    if (fault_lat) begin
      next_fi_state = GDS_FI_FAULT;
    end
  end

  // Interval timer restarts at each state change
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      fi_state <= GDS_FI_IDLE;
      fi_cnt <= '0;
      fault_indicator_n_o <= 1'b0;
      fault_indicator_n_oe <= 1'b0;
    end else if (ce) begin
      fi_state <= next_fi_state;
      fi_cnt <= (next_fi_state != fi_state) ? '0 : fi_cnt + 1'b1;
      fault_indicator_n_o <= 1'b0;
      fault_indicator_n_oe <= (next_fi_state == GDS_FI_LOW) ||
                              (next_fi_state == GDS_FI_FAULT);
    end
  end

  // ---- Supply good: 56 us low, then held until regulator recovers
  gds_sg_state_t sg_state, next_sg_state;
  logic [TW-1:0] sg_cnt;
  logic sg_trig;
  assign sg_trig = (reg_uv_s && !reg_uv_q) || (wd_s && !wd_q);

  always_comb begin
    next_sg_state = sg_state;
    case (sg_state)
      GDS_SG_OK: if (sg_trig) next_sg_state = GDS_SG_HOLD;
      GDS_SG_HOLD: if (sg_cnt == TW'(HOLD_CYCLES - 1)) next_sg_state = GDS_SG_WAIT;
      GDS_SG_WAIT: if (!reg_uv_s && !wd_s) next_sg_state = GDS_SG_OK;
      default: next_sg_state = GDS_SG_OK;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sg_state <= GDS_SG_OK;
      sg_cnt <= '0;
      supply_good_out <= 1'b1;
    end else if (ce) begin
      sg_state <= next_sg_state;
      sg_cnt <= (next_sg_state != sg_state) ? '0 : sg_cnt + 1'b1;
      supply_good_out <= (next_sg_state == GDS_SG_OK);
    end
  end
endmodule : gds_supervisor

// File: test/gds_supervisor_checker.sv
// Port-level assertions for the fault supervisor
module gds_supervisor_checker
  import gds_pkg::*;
#(
  parameter int HOLD_CYCLES = GDS_HOLD_CYC,
  parameter int NUM_WARN = 4,
  parameter int NUM_FAULT = 4
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [NUM_WARN-1:0] warn_cond,
  input wire logic [NUM_FAULT-1:0] fault_cond,
  input wire logic [3:0] thermal_flag,
  input wire logic regulator_undervolt,
  input wire logic [5:0] gate_out,
  input wire logic fault_indicator_n_oe,
  input wire logic supply_good_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  int sg_low_cnt;
  // Supply-good low stretch, too long for a repetition
  always_ff @(posedge ref_clk) begin
    if (!reset_n || supply_good_out) begin
      sg_low_cnt <= 0;
    end else begin
      sg_low_cnt <= sg_low_cnt + 1;
    end
  end
  // Fault onset, then a shutdown that must hold
  sequence s_fault_edge;
    $rose(|fault_cond);
  endsequence
  sequence s_shut_held;
    (gate_out == 6'h00 && fault_indicator_n_oe) [*4];
  endsequence
  a_fault_pin_low: assert property (s_fault_edge |-> ##[1:5] fault_indicator_n_oe)
    else $error("fault pin not pulled low");
  a_fault_shut_down: assert property (s_fault_edge |-> ##6 s_shut_held)
    else $error("fault did not shut gates and hold pin");
  a_sg_drop_fast: assert property ($rose(regulator_undervolt) |-> ##[1:5] !supply_good_out)
    else $error("supply good did not drop");
  a_sg_hold_len: assert property ($rose(supply_good_out) |-> sg_low_cnt >= HOLD_CYCLES)
    else $error("supply good low stretch too short");
  a_sg_wait_long: assert property (regulator_undervolt [*6] |-> !supply_good_out)
    else $error("supply good high while regulator out");
  a_warn_pulse_start: assert property ($rose(|warn_cond) && !fault_indicator_n_oe
    |-> ##[2:6] fault_indicator_n_oe)
    else $error("warning did not pull pin low");
  a_thermal_pin_quiet: assert property ($rose(|thermal_flag) && !fault_indicator_n_oe &&
    warn_cond == '0 |=> !fault_indicator_n_oe [*8])
    else $error("thermal flag moved fault pin");
  a_no_cross_on: assert property ((gate_out[2:0] & gate_out[5:3]) == 3'h0)
    else $error("both switches of a phase on");
  a_dead_gap: assert property ($fell(gate_out[0]) |-> !gate_out[3] [*4])
    else $error("dead time shorter than 40 ns");
endmodule : gds_supervisor_checker

bind gds_supervisor gds_supervisor_checker #(
  .HOLD_CYCLES(HOLD_CYCLES), .NUM_WARN(NUM_WARN), .NUM_FAULT(NUM_FAULT)
) u_gds_supervisor_checker (
  .ref_clk(ref_clk), .reset_n(reset_n), .warn_cond(warn_cond), .fault_cond(fault_cond),
  .thermal_flag(thermal_flag), .regulator_undervolt(regulator_undervolt),
  .gate_out(gate_out), .fault_indicator_n_oe(fault_indicator_n_oe),
  .supply_good_out(supply_good_out)
);

// File: test/gds_mcu_model.sv
// Microcontroller model driving serial frames into the supervisor
module gds_mcu_model
  import gds_pkg::*;
(
  input wire logic ref_clk,
  input wire logic spi_sdo,
  output logic spi_sclk = 1'b0,
  output logic spi_cs_n = 1'b1,
  output logic spi_mosi = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // One frame, 5 cycles a level so the synchronisers never miss an edge
  task automatic xfer(input logic rd, input logic [3:0] a, input logic [10:0] d,
      output logic [10:0] q);
    logic [15:0] f;
    f = {rd, a, d};
    q = 11'h000;
    spi_cs_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    for (int i = 15; i >= 0; i--) begin
      spi_sclk <= 1'b1;
      spi_mosi <= f[i];
      repeat (5) @(posedge ref_clk);
      spi_sclk <= 1'b0;
      if (i < 11) begin
        q[i] = spi_sdo;
      end
      repeat (5) @(posedge ref_clk);
    end
    spi_cs_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask : xfer
endmodule : gds_mcu_model

// File: test/tb_top.sv
// Self-checking bench for the fault supervisor
module tb_top
  import gds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic gate_enable = 1'b0;
  logic uv = 1'b0;
  logic [5:0] gate_cmd = 6'h00;
  logic [3:0] warn = 4'h0, flt = 4'h0, therm = 4'h0;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_sdo, fi_o, fi_oe, sg;
  logic [5:0] gate_out;
  logic [4:0] thr;
  logic [10:0] rv;
  int err_count = 0, n_checks = 0, cyc = 0;
  // Pulled-up open-drain pin; ideal gates fall below cutoff when undriven
  wire logic fault_pin = fi_oe ? fi_o : 1'b1;
  wire logic [5:0] vgs_low = ~gate_out;
  gds_supervisor #(.HOLD_CYCLES(HOLD)) u_gds_supervisor (
    .ref_clk(ref_clk), .reset_n(reset_n), .ce(1'b1), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_sdo(spi_sdo), .spi_sdo_oe(),
    .gate_enable(gate_enable), .gate_cmd(gate_cmd), .vgs_below_cutoff(vgs_low),
    .vds_trip(6'h00), .warn_cond(warn), .fault_cond(flt), .thermal_flag(therm),
    .regulator_undervolt(uv), .watchdog_fault(1'b0), .gate_out(gate_out),
    .fault_indicator_n_o(fi_o), .fault_indicator_n_oe(fi_oe), .supply_good_out(sg),
    .overcurrent_threshold_sel(thr));
  gds_mcu_model u_gds_mcu_model (.ref_clk(ref_clk), .spi_sdo(spi_sdo),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic rd(input logic [3:0] a, output logic [10:0] d);
    u_gds_mcu_model.xfer(1'b1, a, 11'h000, d);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [10:0] d);
    logic [10:0] junk;
    u_gds_mcu_model.xfer(1'b0, a, d, junk);
  endtask : wr
  // Edges until the pin reads v; 300 means it never did
  task automatic wait_pin(input logic v, output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (fault_pin !== v && n < 300);
  endtask : wait_pin
  task automatic t_regs();
    check("idle pins", {3'h0, gate_out, fault_pin, sg}, 11'h003);
    rd(GDS_ADDR_TIMING, rv);
    check("timing rst", rv, GDS_TIMING_RST);
    wr(GDS_ADDR_TIMING, 11'h05a);
    rd(GDS_ADDR_TIMING, rv);
    check("timing rw", rv, 11'h05a);
    for (int m = 0; m < 3; m++) begin
      wr(GDS_ADDR_OC_CTRL, {3'h0, 5'h15, 3'(m)});
      rd(GDS_ADDR_OC_CTRL, rv);
      check("oc ctrl", rv, {3'h0, 5'h15, 3'(m)});
    end
    check("threshold", {6'h00, thr}, 11'h015);
    rd(4'h3, rv);
    check("unmapped", rv, 11'h000);
    wr(GDS_ADDR_TIMING, 11'h000);
    wr(GDS_ADDR_OC_CTRL, 11'h000);
  endtask : t_regs
  task automatic t_warning();
    int n;
    warn <= 4'h1;
    wait_pin(1'b0, n);
    wait_pin(1'b1, n);
    check("low time", 11'(n), 11'(HOLD));
    wait_pin(1'b0, n);
    check("high time", 11'(n), 11'(HOLD));
    rd(GDS_ADDR_STATUS, rv);
    check("warn set", rv & 11'h00f, 11'h001);
    repeat (HOLD + 8) @(posedge ref_clk);
    wait_pin(1'b0, n);
    check("pin quiet", 11'(n), 11'(300));
    rd(GDS_ADDR_STATUS, rv);
    check("warn held", rv & 11'h00f, 11'h001);
    warn <= 4'h0;
    repeat (8) @(posedge ref_clk);
    rd(GDS_ADDR_STATUS, rv);
    rd(GDS_ADDR_STATUS, rv);
    check("warn gone", rv & 11'h00f, 11'h000);
    warn <= 4'h1;
    wait_pin(1'b0, n);
    check("warn again", 11'(n), 11'h005);
    warn <= 4'h0;
    rd(GDS_ADDR_STATUS, rv);
  endtask : t_warning
  task automatic t_fault();
    int n;
    gate_enable <= 1'b1;
    gate_cmd <= 6'h01;
    repeat (40) @(posedge ref_clk);
    check("high on", 11'(gate_out), 11'h001);
    gate_cmd <= 6'h08;
    repeat (40) @(posedge ref_clk);
    check("low on", 11'(gate_out), 11'h008);
    warn <= 4'h2;
    wait_pin(1'b0, n);
    check("warn gates", 11'(gate_out), 11'h008);
    flt <= 4'h4;
    repeat (10) @(posedge ref_clk);
    check("gates off", 11'(gate_out), 11'h000);
    wait_pin(1'b1, n);
    check("pin held", 11'(n), 11'(300));
    warn <= 4'h0;
    rd(GDS_ADDR_STATUS, rv);
    check("fault bit", rv & 11'h400, 11'h400);
    rd(GDS_ADDR_OC_STATUS, rv);
    check("fault type", rv & 11'h3c0, 11'h100);
    flt <= 4'h0;
    repeat (8) @(posedge ref_clk);
    check("latched", 11'(fault_pin), 11'h000);
    wr(GDS_ADDR_CLEAR, 11'h002);
    rd(GDS_ADDR_CLEAR, rv);
    check("clr self", rv, 11'h000);
    check("pin free", 11'(fault_pin), 11'h001);
    check("gates back", 11'(gate_out), 11'h008);
    flt <= 4'h1;
    repeat (10) @(posedge ref_clk);
    flt <= 4'h0;
    gate_enable <= 1'b0;
    repeat (10) @(posedge ref_clk);
    gate_enable <= 1'b1;
    repeat (10) @(posedge ref_clk);
    check("en pulse", 11'(fault_pin), 11'h001);
    gate_cmd <= 6'h00;
  endtask : t_fault
  task automatic t_supply();
    int n;
    uv <= 1'b1;
    repeat (3) @(posedge ref_clk);
    uv <= 1'b0;
    repeat (6) @(posedge ref_clk);
    check("sg low", 11'(sg), 11'h000);
    repeat (HOLD + 4) @(posedge ref_clk);
    check("sg back", 11'(sg), 11'h001);
    uv <= 1'b1;
    repeat (HOLD + 30) @(posedge ref_clk);
    check("sg wait", 11'(sg), 11'h000);
    uv <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check("sg up", 11'(sg), 11'h001);
    therm <= 4'ha;
    rd(GDS_ADDR_STATUS, rv);
    check("therm live", rv & 11'h0f0, 11'h0a0);
    wait_pin(1'b0, n);
    check("therm pin", 11'(n), 11'(300));
    therm <= 4'h0;
    rd(GDS_ADDR_STATUS, rv);
    check("therm off", rv & 11'h0f0, 11'h000);
  endtask : t_supply
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_warning();
    t_fault();
    t_supply();
    tally_and_finish();
  end
endmodule : tb_top
